// file: hdl/adc_conversion_sequencer.sv
// Conversion sequencer: registers, trigger handling, acquisition timing, accumulation
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Debug halt with run bit clear stops new starts; running work completes.
// - With run bit set, debug halt has no effect on operation.
// - Without amplifier, acquisition lasts acquire length plus half a cycle.
// - With amplifier, acquisition lasts length plus one, then amplifier sampling.
// - Continuous restart launches a new conversion once the last one completes.
// - Alignment bit puts single and scaled results at the top of the 16-bit field.
// - Count code 0 means no summing; 1..10 sum 2..1024 samples.
// - Latest individual sample stays readable apart from the accumulated result.
// - Two-input bit selects unsigned single-ended or signed differential conversion.
// - Mode 0 converts once at 8 bits, mode 1 once at 12 bits.
// - Series modes take one trigger per conversion; mode 3 scales the sum.
// - Burst modes run all conversions from one trigger; mode 5 scales.
// - Leaving an accumulating mode for a single mode clears the accumulator.
// - Writing start value 0 aborts any conversion in progress.
// - Start value 1 converts at once and returns to 0 unless continuous.
// - Start values 2 and 3 fire on writes to the input selectors.
// - Start value 4 fires on an incoming event; above 4 never fires.
// - Writing start value 1 while disabled stores the stop value instead.
// - A trigger arriving during a conversion sets the overrun flag.
// - Busy reads 1 during conversion, settling or a pending trigger, 0 once all end.
module adc_conversion_sequencer (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register port
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [7:0] rdata_o,
	// System inputs
	input wire logic debug_halted_i,
	input wire logic event_trigger_i,
	// Analog core
	output logic core_acquire_o,
	output logic core_acquire_half_o,
	output logic core_amp_sample_o,
	output logic core_start_o,
	output logic core_eight_bit_o,
	output logic core_two_input_o,
	output logic core_amp_enable_o,
	output logic [5:0] core_positive_select_o,
	output logic [5:0] core_negative_select_o,
	input wire logic core_done_i,
	input wire logic [11:0] core_data_i
);
	import adc_seq_pkg::*;

	// Shifts a value to the top of the 16-bit field when alignment is requested
	function automatic logic [31:0] align_out(input logic [31:0] v, input logic [4:0] w,
		input logic left);
		logic [4:0] sh;
		sh = 5'd16 - w;
		align_out = left ? (v << sh) : v;
	endfunction : align_out

	logic enable_q;
	logic run_while_halted_q;
	logic [7:0] acquire_length_q;
	logic continuous_restart_q;
	logic msb_align_output_q;
	logic [3:0] accumulation_count_q;
	logic two_input_select_q;
	logic [2:0] mode_q;
	logic [2:0] start_q;
	logic [7:0] amplifier_control_q;
	logic [1:0] via_q;
	logic [5:0] positive_input_selector_q;
	logic [5:0] negative_input_selector_q;
	logic trigger_overrun_flag_q;
	logic [31:0] result_q;
	logic [15:0] sample_q;
	logic [31:0] acc_q;
	logic [10:0] acc_num_q;
	logic pend_q;
	logic start_pulse_q;
	logic [7:0] rdata_q;
	seq_state_e state_q;

	// Decoded writes
	logic wr_ctrl, wr_cmd, wr_pos, wr_neg, wr_amp, wr_flags;
	assign wr_ctrl = wr_i && (addr_i == OFS_PRIMARY_CTRL);
	assign wr_cmd = wr_i && (addr_i == OFS_COMMAND);
	assign wr_pos = wr_i && (addr_i == OFS_POS_SEL);
	assign wr_neg = wr_i && (addr_i == OFS_NEG_SEL);
	assign wr_amp = wr_i && (addr_i == OFS_AMP_CTRL);
	assign wr_flags = wr_i && (addr_i == OFS_FLAGS);

	// Mode and path decode
	logic acc_mode, burst_mode, scaled_mode, mode_valid, amp_path, halt_block;
	logic [3:0] acc_code;
	logic [10:0] acc_target;
	logic [7:0] amp_len;
	assign acc_mode = (mode_q >= MODE_SERIES) && (mode_q <= MODE_BURST_SCALED);
	assign burst_mode = (mode_q == MODE_BURST) || (mode_q == MODE_BURST_SCALED);
	assign scaled_mode = (mode_q == MODE_SERIES_SCALED) || (mode_q == MODE_BURST_SCALED);
	assign mode_valid = (mode_q <= MODE_BURST_SCALED);
	// Reserved count codes fall back to no summing
	assign acc_code = (accumulation_count_q > ACC_CODE_MAX) ? 4'h0 : accumulation_count_q;
	assign acc_target = 11'h001 << acc_code;
	assign amp_path = (via_q == 2'h1) && amplifier_control_q[BIT_AMP_EN];
	assign halt_block = debug_halted_i && !run_while_halted_q;

	always_comb begin
		case (amplifier_control_q[2:1])
			2'h0: amp_len = AMP_CYCLES_SHORT;
			2'h1: amp_len = AMP_CYCLES_MID;
			default: amp_len = AMP_CYCLES_LONG;
		endcase
	end

	// Trigger sources; start values above 4 match none of them
	logic ext_trig, stop_wr, now_wr;
	assign now_wr = wr_cmd && (wdata_i[2:0] == START_NOW) && enable_q;
	assign stop_wr = wr_cmd && (wdata_i[2:0] == START_STOP);
	assign ext_trig = now_wr
		|| (wr_pos && start_q == START_ON_POSITIVE_SELECT_WRITE)
		|| (wr_neg && start_q == START_ON_NEGATIVE_SELECT_WRITE)
		|| (event_trigger_i && start_q == START_ON_EVENT);

	// Timers: one for the acquisition windows, one for settling waits
	logic tmr_load, tmr_last, settle_load, settle_busy;
	logic [7:0] tmr_len;
	cycle_timer u_acq_timer (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.load_i(tmr_load),
		.abort_i(stop_wr),
		.len_i(tmr_len),
		.active_o(),
		.last_o(tmr_last)
	);
	cycle_timer u_settle_timer (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.load_i(settle_load),
		.abort_i(1'b0),
		.len_i(SETTLE_CYCLES - 8'h01),
		.active_o(settle_busy),
		.last_o()
	);
	assign settle_load = wr_pos || wr_neg || wr_amp || (wr_ctrl && wdata_i[BIT_ENABLE] && !enable_q);

	// Sequencing decisions
	logic launch, conv_done, batch_full, complete, restart;
	logic [31:0] smp_ext, acc_sum, scaled, eight_ext;
	assign launch = pend_q && (state_q == ST_IDLE) && !settle_busy && !halt_block
		&& enable_q && mode_valid && !stop_wr;
	assign conv_done = (state_q == ST_CONVERT) && core_done_i;
	// Differential samples are signed, single-ended ones unsigned
	assign smp_ext = two_input_select_q ? {{20{core_data_i[11]}}, core_data_i}
		: {20'h00000, core_data_i};
	assign eight_ext = two_input_select_q ? {{24{core_data_i[7]}}, core_data_i[7:0]}
		: {24'h000000, core_data_i[7:0]};
	assign acc_sum = acc_q + smp_ext;
	assign batch_full = (acc_num_q + 11'h001) == acc_target;
	assign complete = conv_done && (!acc_mode || batch_full);
	assign scaled = $signed(acc_sum) >>> acc_code;
	assign restart = complete && continuous_restart_q && enable_q && (start_q != START_STOP);

	// Acquisition timer loads: input window, then optional amplifier window
	always_comb begin
		tmr_load = 1'b0;
		tmr_len = acquire_length_q;
		if (launch) begin
			tmr_load = 1'b1;
		end else if (conv_done && acc_mode && burst_mode && !batch_full) begin
			tmr_load = 1'b1;
		end else if (state_q == ST_ACQUIRE && tmr_last && amp_path) begin
			tmr_load = 1'b1;
			tmr_len = amp_len - 8'h01;
		end
	end

	// Main sequencer
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
		end else if (stop_wr) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (launch) begin
						state_q <= ST_ACQUIRE;
					end
				end
				ST_ACQUIRE: begin
					if (tmr_last) begin
						state_q <= amp_path ? ST_AMP_ACQUIRE : ST_CONVERT;
					end
				end
				ST_AMP_ACQUIRE: begin
					if (tmr_last) begin
						state_q <= ST_CONVERT;
					end
				end
				ST_CONVERT: begin
					if (conv_done) begin
						// A running burst finishes even under debug halt
						if (acc_mode && burst_mode && !batch_full) begin
							state_q <= ST_ACQUIRE;
						end else begin
							state_q <= ST_IDLE;
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Conversion start pulse to the core at the end of the acquisition windows
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			start_pulse_q <= 1'b0;
		end else begin
			start_pulse_q <= !stop_wr && tmr_last
				&& ((state_q == ST_ACQUIRE && !amp_path) || state_q == ST_AMP_ACQUIRE);
		end
	end

	// Pending trigger: waits out settling or a debug halt before it launches
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			pend_q <= 1'b0;
		end else if (stop_wr) begin
			pend_q <= 1'b0;
		end else if (restart) begin
			pend_q <= 1'b1;
		end else if (ext_trig && state_q == ST_IDLE) begin
			pend_q <= 1'b1;
		end else if (launch) begin
			pend_q <= 1'b0;
		end
	end

	// Overrun: set wins over a clear written in the same cycle
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			trigger_overrun_flag_q <= 1'b0;
		end else if (ext_trig && (state_q != ST_IDLE || pend_q)) begin
			trigger_overrun_flag_q <= 1'b1;
		end else if (wr_flags && wdata_i[BIT_TRIG_OVR]) begin
			trigger_overrun_flag_q <= 1'b0;
		end
	end

	// Accumulator, latest sample and result
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			acc_q <= 32'h00000000;
			acc_num_q <= 11'h000;
			sample_q <= 16'h0000;
			result_q <= 32'h00000000;
		end else if (wr_cmd && acc_mode && wdata_i[6:4] <= MODE_ONE_SHOT_TWELVE_BIT) begin
			acc_q <= 32'h00000000;
			acc_num_q <= 11'h000;
		end else if (conv_done) begin
			sample_q <= smp_ext[15:0];
			if (!acc_mode) begin
				if (mode_q == MODE_ONE_SHOT_EIGHT_BIT) begin
					result_q <= align_out(eight_ext, 5'd8, msb_align_output_q);
				end else begin
					result_q <= align_out(smp_ext, 5'd12, msb_align_output_q);
				end
			end else if (batch_full) begin
				acc_q <= 32'h00000000;
				acc_num_q <= 11'h000;
				// Unscaled sums may exceed 16 bits, so alignment applies to scaled sums only
				if (scaled_mode) begin
					result_q <= align_out(scaled, 5'd12, msb_align_output_q);
				end else begin
					result_q <= acc_sum;
				end
			end else begin
				acc_q <= acc_sum;
				acc_num_q <= acc_num_q + 11'h001;
			end
		end
	end

	// Software registers
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			enable_q <= RST_ZERO[0];
			run_while_halted_q <= RST_ZERO[0];
			acquire_length_q <= RST_ZERO;
			continuous_restart_q <= RST_ZERO[0];
			msb_align_output_q <= RST_ZERO[0];
			accumulation_count_q <= RST_ZERO[3:0];
			two_input_select_q <= RST_ZERO[0];
			mode_q <= RST_ZERO[2:0];
			amplifier_control_q <= RST_AMP_CTRL;
			via_q <= RST_ZERO[1:0];
			positive_input_selector_q <= RST_ZERO[5:0];
			negative_input_selector_q <= RST_ZERO[5:0];
		end else if (wr_i) begin
			case (addr_i)
				OFS_PRIMARY_CTRL: enable_q <= wdata_i[BIT_ENABLE];
				OFS_DEBUG_HALT: run_while_halted_q <= wdata_i[BIT_RUN_HALTED];
				OFS_ACQUIRE_TIME: acquire_length_q <= wdata_i;
				OFS_ACC_FORMAT: begin
					continuous_restart_q <= wdata_i[BIT_CONT_RESTART];
					msb_align_output_q <= wdata_i[BIT_MSB_ALIGN];
					accumulation_count_q <= wdata_i[3:0];
				end
				OFS_COMMAND: begin
					two_input_select_q <= wdata_i[BIT_TWO_INPUT];
					mode_q <= wdata_i[6:4];
				end
				OFS_AMP_CTRL: amplifier_control_q <= wdata_i;
				// The path select is shared by both selector registers
				OFS_POS_SEL: begin
					via_q <= wdata_i[7:6];
					positive_input_selector_q <= wdata_i[5:0];
				end
				OFS_NEG_SEL: begin
					via_q <= wdata_i[7:6];
					negative_input_selector_q <= wdata_i[5:0];
				end
				default: ;
			endcase
		end
	end

	// Start field: written by software, cleared by hardware after a one-off start
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			start_q <= RST_ZERO[2:0];
		end else if (wr_cmd) begin
			if (wdata_i[2:0] == START_NOW && !enable_q) begin
				start_q <= START_STOP;
			end else begin
				start_q <= wdata_i[2:0];
			end
		end else if (complete && start_q == START_NOW && !continuous_restart_q) begin
			start_q <= START_STOP;
		end
	end

	// Read data stands in the cycle after the strobe; unmapped addresses read zero
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			rdata_q <= 8'h00;
		end else if (rd_i) begin
			case (addr_i)
				OFS_PRIMARY_CTRL: rdata_q <= {7'h00, enable_q};
				OFS_FLAGS: rdata_q <= {2'h0, trigger_overrun_flag_q, 5'h00};
				OFS_STATUS: rdata_q <= {7'h00, (state_q != ST_IDLE) || pend_q || settle_busy};
				OFS_DEBUG_HALT: rdata_q <= {7'h00, run_while_halted_q};
				OFS_ACQUIRE_TIME: rdata_q <= acquire_length_q;
				OFS_ACC_FORMAT: rdata_q <= {2'h0, continuous_restart_q, msb_align_output_q,
					accumulation_count_q};
				OFS_COMMAND: rdata_q <= {two_input_select_q, mode_q, 1'b0, start_q};
				OFS_AMP_CTRL: rdata_q <= amplifier_control_q;
				OFS_POS_SEL: rdata_q <= {via_q, positive_input_selector_q};
				OFS_NEG_SEL: rdata_q <= {via_q, negative_input_selector_q};
				OFS_RESULT0: rdata_q <= result_q[7:0];
				OFS_RESULT1: rdata_q <= result_q[15:8];
				OFS_RESULT2: rdata_q <= result_q[23:16];
				OFS_RESULT3: rdata_q <= result_q[31:24];
				OFS_SAMPLE0: rdata_q <= sample_q[7:0];
				OFS_SAMPLE1: rdata_q <= sample_q[15:8];
				default: rdata_q <= 8'h00;
			endcase
		end
	end

	// Core controls; the half flag tells the core to close the window half a cycle early
	assign rdata_o = rdata_q;
	assign core_acquire_o = (state_q == ST_ACQUIRE);
	assign core_acquire_half_o = !amp_path;
	assign core_amp_sample_o = (state_q == ST_AMP_ACQUIRE);
	assign core_start_o = start_pulse_q;
	assign core_eight_bit_o = (mode_q == MODE_ONE_SHOT_EIGHT_BIT);
	assign core_two_input_o = two_input_select_q;
	assign core_amp_enable_o = amp_path;
	assign core_positive_select_o = positive_input_selector_q;
	assign core_negative_select_o = two_input_select_q ? negative_input_selector_q : 6'h00;

endmodule : adc_conversion_sequencer

`default_nettype wire

// file: pkg/adc_seq_pkg.sv
// Register map, field layout and timing constants of the conversion sequencer
package adc_seq_pkg;

	// Register offsets
	localparam logic [7:0] OFS_PRIMARY_CTRL = 8'h00;
	localparam logic [7:0] OFS_FLAGS = 8'h05;
	localparam logic [7:0] OFS_STATUS = 8'h06;
	localparam logic [7:0] OFS_DEBUG_HALT = 8'h07;
	localparam logic [7:0] OFS_ACQUIRE_TIME = 8'h08;
	localparam logic [7:0] OFS_ACC_FORMAT = 8'h09;
	localparam logic [7:0] OFS_COMMAND = 8'h0A;
	localparam logic [7:0] OFS_AMP_CTRL = 8'h0B;
	localparam logic [7:0] OFS_POS_SEL = 8'h0C;
	localparam logic [7:0] OFS_NEG_SEL = 8'h0D;
	localparam logic [7:0] OFS_RESULT0 = 8'h10;
	localparam logic [7:0] OFS_RESULT1 = 8'h11;
	localparam logic [7:0] OFS_RESULT2 = 8'h12;
	localparam logic [7:0] OFS_RESULT3 = 8'h13;
	localparam logic [7:0] OFS_SAMPLE0 = 8'h14;
	localparam logic [7:0] OFS_SAMPLE1 = 8'h15;

	// Field positions
	localparam int BIT_ENABLE = 0;
	localparam int BIT_TRIG_OVR = 5;
	localparam int BIT_BUSY = 0;
	localparam int BIT_RUN_HALTED = 0;
	localparam int BIT_CONT_RESTART = 5;
	localparam int BIT_MSB_ALIGN = 4;
	localparam int BIT_TWO_INPUT = 7;
	localparam int BIT_AMP_EN = 0;

	// Reset values
	localparam logic [7:0] RST_ZERO = 8'h00;
	localparam logic [7:0] RST_AMP_CTRL = 8'h04;

	// Conversion modes
	localparam logic [2:0] MODE_ONE_SHOT_EIGHT_BIT = 3'h0;
	localparam logic [2:0] MODE_ONE_SHOT_TWELVE_BIT = 3'h1;
	localparam logic [2:0] MODE_SERIES = 3'h2;
	localparam logic [2:0] MODE_SERIES_SCALED = 3'h3;
	localparam logic [2:0] MODE_BURST = 3'h4;
	localparam logic [2:0] MODE_BURST_SCALED = 3'h5;

	// Start field values
	localparam logic [2:0] START_STOP = 3'h0;
	localparam logic [2:0] START_NOW = 3'h1;
	localparam logic [2:0] START_ON_POSITIVE_SELECT_WRITE = 3'h2;
	localparam logic [2:0] START_ON_NEGATIVE_SELECT_WRITE = 3'h3;
	localparam logic [2:0] START_ON_EVENT = 3'h4;

	// Accumulation: largest legal count code (1024 samples)
	localparam logic [3:0] ACC_CODE_MAX = 4'hA;

	// Amplifier sampling lengths in converter clock cycles
	localparam logic [7:0] AMP_CYCLES_SHORT = 8'h06;
	localparam logic [7:0] AMP_CYCLES_MID = 8'h0F;
	localparam logic [7:0] AMP_CYCLES_LONG = 8'h14;

	// Settling wait after an input or amplifier change, in cycles
	localparam logic [7:0] SETTLE_CYCLES = 8'h04;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ACQUIRE,
		ST_AMP_ACQUIRE,
		ST_CONVERT
	} seq_state_e;

endpackage : adc_seq_pkg

// file: hdl/cycle_timer.sv
// Loadable down counter that holds a window open for a programmed number of cycles
`timescale 1ns/1ps
`default_nettype none

module cycle_timer (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic load_i,
	input wire logic abort_i,
	input wire logic [7:0] len_i,
	// Status
	output logic active_o,
	output logic last_o
);

	logic [7:0] cnt_q;
	logic run_q;

	// Window stays open for len_i + 1 cycles after a load
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			cnt_q <= 8'h00;
			run_q <= 1'b0;
		end else if (abort_i) begin
			cnt_q <= 8'h00;
			run_q <= 1'b0;
		end else if (load_i) begin
			cnt_q <= len_i;
			run_q <= 1'b1;
		end else if (run_q) begin
			if (cnt_q == 8'h00) begin
				run_q <= 1'b0;
			end else begin
				cnt_q <= cnt_q - 8'h01;
			end
		end
	end

	// Last cycle of the window, seen by the sequencer to move on
	assign active_o = run_q;
	assign last_o = run_q && (cnt_q == 8'h00);

endmodule : cycle_timer

`default_nettype wire

// file: testbench/adc_seq_props.sv
// Port-level checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_seq_props (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Register writes
	input wire logic [7:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic wr_i,
	// Core side
	input wire logic core_acquire_o,
	input wire logic core_acquire_half_o,
	input wire logic core_amp_sample_o,
	input wire logic core_start_o,
	input wire logic core_eight_bit_o,
	input wire logic core_two_input_o,
	input wire logic core_amp_enable_o,
	input wire logic [5:0] core_negative_select_o
);
	import adc_seq_pkg::*;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	logic [7:0] len_q;
	logic [8:0] cnt_q;
	// Shadow of the acquire length; an edit mid-window would skew the count
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) len_q <= RST_ZERO;
		else if (wr_i && addr_i == OFS_ACQUIRE_TIME) len_q <= wdata_i;
	end
	// Cycles the acquire window has been open; 9 bits so 255+1 fits
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) cnt_q <= 9'h000;
		else cnt_q <= core_acquire_o ? cnt_q + 9'h001 : 9'h000;
	end
	half_select_a:
		assert property (core_acquire_half_o == !core_amp_enable_o)
		else $error("Half-cycle select disagrees with amplifier path");
	acq_length_a:
		assert property ($fell(core_acquire_o) && !$past(wr_i) |-> cnt_q == {1'b0, len_q} + 9'h001)
		else $error("Acquire window length wrong");
	start_after_window_a:
		assert property ($rose(core_start_o) |-> $past(core_acquire_o || core_amp_sample_o))
		else $error("Start pulse without a preceding window");
	start_pulse_a:
		assert property (core_start_o |=> !core_start_o)
		else $error("Start pulse longer than one cycle");
	amp_follow_a:
		assert property ($fell(core_acquire_o) && core_amp_enable_o && !$past(wr_i) |-> core_amp_sample_o)
		else $error("Amplifier sampling did not follow acquisition");
	neg_select_a:
		assert property (!core_two_input_o |-> core_negative_select_o == 6'h00)
		else $error("Negative selector used in single-ended mode");
	two_input_select_follow_a:
		assert property (wr_i && addr_i == OFS_COMMAND |=> core_two_input_o == $past(wdata_i[7]))
		else $error("Differential select does not follow command");
	eight_bit_a:
		assert property (wr_i && addr_i == OFS_COMMAND |=> core_eight_bit_o == ($past(wdata_i[6:4]) == 3'h0))
		else $error("Eight-bit select does not follow mode");
	abort_idle_a:
		assert property (wr_i && addr_i == OFS_COMMAND && wdata_i[2:0] == START_STOP
			|=> !(core_acquire_o || core_amp_sample_o || core_start_o) [*2])
		else $error("Conversion continued after stop");
	cover property ($rose(core_amp_sample_o));
	cover property (core_start_o && core_eight_bit_o);
	cover property (core_start_o && core_two_input_o);
endmodule : adc_seq_props
bind adc_conversion_sequencer adc_seq_props i_adc_seq_props (
	.mclk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .core_acquire_o, .core_acquire_half_o,
	.core_amp_sample_o, .core_start_o, .core_eight_bit_o, .core_two_input_o,
	.core_amp_enable_o, .core_negative_select_o
);
`default_nettype wire

// file: testbench/adc_core_model.sv
// Behavioural analog core: answers each start pulse with a done pulse and data
`timescale 1ns/1ps
`default_nettype none
module adc_core_model (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Sequencer side
	input wire logic core_start_i,
	output logic core_done_o,
	output logic [11:0] core_data_o,
	// Bench control: conversion time and value
	input wire logic [7:0] delay_i,
	input wire logic [11:0] sample_i
);
	logic [7:0] cnt_q;
	logic busy_q;
	// Count down the conversion time, then pulse done once
	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			busy_q <= 1'b0;
			cnt_q <= 8'h00;
			core_done_o <= 1'b0;
		end else begin
			core_done_o <= busy_q && cnt_q == 8'h00;
			if (core_start_i) begin
				busy_q <= 1'b1;
				cnt_q <= delay_i;
			end else if (cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
			else busy_q <= 1'b0;
		end
	end
	// Outside done the data is inverted so a stale capture never matches
	assign core_data_o = core_done_o ? sample_i : ~sample_i;
endmodule : adc_core_model
`default_nettype wire

// file: testbench/tb_top.sv
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import adc_seq_pkg::*;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic halted = 1'b0;
	logic evt = 1'b0;
	logic [7:0] delay = 8'h02;
	logic [11:0] samp = 12'h000;
	logic [7:0] rdata, d;
	logic acq, half, amp, start, eight, two, ampen, done;
	logic [5:0] psel, nsel;
	logic [11:0] cdata;
	int n_fail = 0;
	int n_tests = 0;
	int n_done = 0;
	int n_starts = 0;
	int acq_cur = 0, acq_last = 0, amp_cur = 0, amp_last = 0, s0, b;
	always #20 mclk = ~mclk;
	adc_conversion_sequencer i_adc_conversion_sequencer (
		.mclk_i(mclk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
		.rdata_o(rdata), .debug_halted_i(halted), .event_trigger_i(evt), .core_acquire_o(acq),
		.core_acquire_half_o(half), .core_amp_sample_o(amp), .core_start_o(start),
		.core_eight_bit_o(eight), .core_two_input_o(two), .core_amp_enable_o(ampen),
		.core_positive_select_o(psel), .core_negative_select_o(nsel), .core_done_i(done),
		.core_data_i(cdata)
	);
	adc_core_model i_adc_core_model (
		.mclk_i(mclk), .rst_n_i(rst_n), .core_start_i(start), .core_done_o(done),
		.core_data_o(cdata), .delay_i(delay), .sample_i(samp)
	);
	// Count handshakes and window lengths as the core sees them
	always @(posedge mclk) begin
		if (start === 1'b1) n_starts++;
		if (done === 1'b1) n_done++;
		if (acq === 1'b1) acq_cur++;
		else if (acq_cur != 0) begin
			acq_last = acq_cur;
			acq_cur = 0;
		end
		if (amp === 1'b1) amp_cur++;
		else if (amp_cur != 0) begin
			amp_last = amp_cur;
			amp_cur = 0;
		end
	end
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge mclk);
		addr <= a;
		rd <= 1'b1;
		@(posedge mclk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		rd_reg(a, d);
		chk($sformatf("reg %h", a), {24'h0, e}, {24'h0, d});
	endtask : rchk
	task automatic rres(input logic [15:0] e);
		logic [7:0] lo;
		rd_reg(OFS_RESULT0, lo);
		rd_reg(OFS_RESULT1, d);
		chk("result", {16'h0, e}, {16'h0, d, lo});
	endtask : rres
	task automatic wait_done(input int tgt);
		for (int i = 0; i < 3000 && n_done < tgt; i++) @(posedge mclk);
		if (n_done < tgt) begin
			chk("conversions", tgt, n_done);
			finish_test();
		end
		repeat (3) @(posedge mclk);
	endtask : wait_done
	task automatic conv(input logic [7:0] c, input int n);
		int base;
		base = n_done;
		wr_reg(OFS_COMMAND, c);
		wait_done(base + n);
	endtask : conv
	// Trigger for a start code: selector write or event pulse
	task automatic fire(input int s);
		if (s == 2) wr_reg(OFS_POS_SEL, 8'h01);
		else if (s == 3) wr_reg(OFS_NEG_SEL, 8'h02);
		else begin
			@(posedge mclk);
			evt <= 1'b1;
			@(posedge mclk);
			evt <= 1'b0;
		end
	endtask : fire
	initial begin
		repeat (3) @(posedge mclk);
		rst_n <= 1'b1;
		rchk(OFS_DEBUG_HALT, RST_ZERO);
		rchk(OFS_ACQUIRE_TIME, RST_ZERO);
		rchk(OFS_COMMAND, RST_ZERO);
		rchk(OFS_AMP_CTRL, RST_AMP_CTRL);
		rchk(8'h3F, RST_ZERO);
		wr_reg(OFS_ACC_FORMAT, 8'hFF);
		rchk(OFS_ACC_FORMAT, 8'h3F);
		chk("half", 1, half);
		wr_reg(OFS_ACC_FORMAT, RST_ZERO);
		wr_reg(OFS_COMMAND, 8'h11);
		rchk(OFS_COMMAND, 8'h10);
		wr_reg(OFS_PRIMARY_CTRL, 8'h01);
		rchk(OFS_STATUS, 8'h01);
		repeat (6) @(posedge mclk);
		rchk(OFS_STATUS, RST_ZERO);
		$display("registers done");
		// Single conversions: 12-bit, left adjusted, 8-bit
		wr_reg(OFS_ACQUIRE_TIME, 8'h03);
		samp <= 12'hABC;
		conv(8'h11, 1);
		chk("acquire cycles", 4, acq_last);
		rres(16'h0ABC);
		rchk(OFS_COMMAND, 8'h10);
		rchk(OFS_SAMPLE1, 8'h0A);
		wr_reg(OFS_ACC_FORMAT, 8'h10);
		conv(8'h11, 1);
		rres(16'hABC0);
		wr_reg(OFS_ACC_FORMAT, RST_ZERO);
		conv(8'h01, 1);
		rres(16'h00BC);
		$display("single done");
		// Burst of four from one trigger, plain then scaled
		samp <= 12'h123;
		wr_reg(OFS_ACC_FORMAT, 8'h02);
		for (int m = 4; m < 6; m++) begin
			s0 = n_starts;
			conv({1'b0, 3'(m), 4'h1}, 4);
			chk("burst starts", 4, n_starts - s0);
			rres(m == 4 ? 16'h048C : 16'h0123);
		end
		// Half a series, a switch to single mode, then a full series of two
		wr_reg(OFS_ACC_FORMAT, 8'h01);
		conv(8'h21, 1);
		wr_reg(OFS_COMMAND, 8'h10);
		conv(8'h21, 1);
		conv(8'h21, 1);
		rres(16'h0246);
		$display("accumulate done");
		// Selector writes and events as triggers; code 5 never fires
		wr_reg(OFS_ACC_FORMAT, RST_ZERO);
		for (int s = 2; s < 6; s++) begin
			s0 = n_starts;
			b = n_done;
			wr_reg(OFS_COMMAND, 8'h10 | 8'(s));
			fire(s);
			if (s < 5) wait_done(b + 1);
			else repeat (40) @(posedge mclk);
			chk("trigger starts", (s < 5) ? 1 : 0, n_starts - s0);
		end
		// A second event while converting sets the overrun flag
		wr_reg(OFS_COMMAND, 8'h14);
		delay <= 8'h28;
		b = n_done;
		fire(4);
		repeat (10) @(posedge mclk);
		fire(4);
		wait_done(b + 1);
		rd_reg(OFS_FLAGS, d);
		chk("overrun", 1, d[BIT_TRIG_OVR]);
		wr_reg(OFS_FLAGS, 8'h20);
		rd_reg(OFS_FLAGS, d);
		chk("overrun clear", 0, d[BIT_TRIG_OVR]);
		// Stop mid-conversion keeps the old result
		samp <= 12'h555;
		wr_reg(OFS_COMMAND, 8'h11);
		repeat (12) @(posedge mclk);
		wr_reg(OFS_COMMAND, 8'h10);
		repeat (60) @(posedge mclk);
		rres(16'h0123);
		rchk(OFS_STATUS, RST_ZERO);
		$display("triggers done");
		// Continuous restart: one write yields three results
		delay <= 8'h02;
		wr_reg(OFS_ACC_FORMAT, 8'h20);
		conv(8'h11, 3);
		rchk(OFS_COMMAND, 8'h11);
		wr_reg(OFS_COMMAND, 8'h10);
		wr_reg(OFS_ACC_FORMAT, RST_ZERO);
		// Let a late done of the aborted conversion pass before counting
		repeat (10) @(posedge mclk);
		// Debug halt holds off a start unless running while halted
		halted <= 1'b1;
		s0 = n_starts;
		b = n_done;
		wr_reg(OFS_COMMAND, 8'h11);
		repeat (30) @(posedge mclk);
		chk("halted starts", 0, n_starts - s0);
		halted <= 1'b0;
		wait_done(b + 1);
		wr_reg(OFS_DEBUG_HALT, 8'h01);
		halted <= 1'b1;
		conv(8'h11, 1);
		halted <= 1'b0;
		$display("restart and halt done");
		// Amplifier path: full-cycle acquire then six amplifier cycles
		wr_reg(OFS_AMP_CTRL, 8'h01);
		wr_reg(OFS_POS_SEL, 8'h41);
		conv(8'h11, 1);
		chk("amp acquire", 4, acq_last);
		chk("amp sample", 6, amp_last);
		chk("half", 0, half);
		chk("pos sel", 1, psel);
		// Differential: negative selector used, sample sign-extended
		wr_reg(OFS_NEG_SEL, 8'h45);
		samp <= 12'h800;
		conv(8'h91, 1);
		chk("neg sel", 5, nsel);
		rchk(OFS_SAMPLE1, 8'hF8);
		wr_reg(OFS_COMMAND, 8'h10);
		#1 chk("neg sel single", 0, nsel);
		$display("amplifier and differential done");
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
